// ===== hdl/sdl_host.sv
// Host side: sends one sixteen bit frame per request, reads chain data back
`timescale 1ns/100ps
module sdl_host (
    sdl_link_if.host link,
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic wr_valid,
    input wire logic [sdl_pkg::FRAME_W-1:0] wr_word,
    output logic wr_ready,
    output logic rd_valid,
    output logic [sdl_pkg::FRAME_W-1:0] rd_word
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_HIGH = 2'b11,
        ST_GAP = 2'b10
    } sdl_state_t;
    typedef struct packed {
        sdl_state_t st;
        logic [sdl_pkg::DIV_W-1:0] div;
        logic [sdl_pkg::CNT_W-1:0] cnt;
        logic [sdl_pkg::FRAME_W-1:0] tx;
        logic [sdl_pkg::FRAME_W-1:0] rx;
        logic sclk;
        logic cs_n;
        logic sync1;
        logic sync2;
        logic rd_valid;
        logic [sdl_pkg::FRAME_W-1:0] rd_word;
    } sdl_host_t;
    sdl_host_t s_ff;
    sdl_host_t nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.sync1 = link.dout;
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.rd_valid = 1'b0;
        nxt_s.div = s_ff.div + 4'h1;
        case (s_ff.st)
            ST_IDLE:
            begin
                nxt_s.div = sdl_pkg::CNT_ZERO[sdl_pkg::DIV_W-1:0];
                if (wr_valid)
                begin
                    nxt_s.tx = wr_word;
                    nxt_s.cs_n = 1'b0;
                    nxt_s.cnt = sdl_pkg::CNT_ZERO;
                    nxt_s.st = ST_LOW;
                end
            end
            ST_LOW:
            begin
                if (s_ff.div == sdl_pkg::SCLK_HALF)
                begin
                    nxt_s.div = '0;
                    nxt_s.sclk = 1'b1;
                    nxt_s.rx = {s_ff.rx[sdl_pkg::FRAME_W-2:0], s_ff.sync2};
                    nxt_s.st = ST_HIGH;
                end
            end
            ST_HIGH:
            begin
                if (s_ff.div == sdl_pkg::SCLK_HALF)
                begin
                    nxt_s.div = '0;
                    nxt_s.sclk = 1'b0;
                    nxt_s.tx = {s_ff.tx[sdl_pkg::FRAME_W-2:0], 1'b0};
                    nxt_s.cnt = s_ff.cnt + 5'h01;
                    nxt_s.st = ST_LOW;
                    if (s_ff.cnt == sdl_pkg::FRAME_LAST)
                    begin
                        nxt_s.st = ST_GAP;
                    end
                end
            end
            ST_GAP:
            begin
                nxt_s.cs_n = 1'b1;
                if (s_ff.div == sdl_pkg::CS_HIGH_HALVES)
                begin
                    nxt_s.rd_valid = 1'b1;
                    nxt_s.rd_word = s_ff.rx;
                    nxt_s.st = ST_IDLE;
                end
            end
            default:
            begin
                nxt_s.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_ff <= '{st: ST_IDLE, div: '0, cnt: '0, tx: '0, rx: '0, sclk: 1'b0, cs_n: 1'b1,
                      sync1: 1'b0, sync2: 1'b0, rd_valid: 1'b0, rd_word: '0};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign link.sclk = s_ff.sclk;
    assign link.cs_n = s_ff.cs_n;
    assign link.din = s_ff.tx[sdl_pkg::FRAME_W-1];
    assign wr_ready = (s_ff.st == ST_IDLE);
    assign rd_valid = s_ff.rd_valid;
    assign rd_word = s_ff.rd_word;
endmodule

// ===== hdl/sdl_pkg.sv
// Shared constants for the serial converter loader link
package sdl_pkg;
    localparam int unsigned SHIFT_W = 16;
    localparam int unsigned CODE_W = 10;
    localparam int unsigned LATCH_W = 12;
    localparam int unsigned SUB_W = 2;
    localparam int unsigned FRAME_W = 16;
    localparam int unsigned CNT_W = 5;
    localparam int unsigned DIV_W = 4;
    localparam logic [DIV_W-1:0] SCLK_HALF = 4'h3;
    localparam logic [DIV_W-1:0] CS_HIGH_HALVES = 4'h2;
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 16'h0000;
    localparam logic [LATCH_W-1:0] LATCH_RST = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam logic [CNT_W-1:0] FRAME_LAST = 5'h0f;
endpackage

// ===== hdl/sdl_link_if.sv
// Four-wire link between host and converter loader
`timescale 1ns/100ps
interface sdl_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    modport host (output sclk, output cs_n, output din, input dout);
    modport dev (input sclk, input cs_n, input din, output dout);
endinterface

// ===== hdl/sdl_dev.sv
// Converter side: shift register, converter latch, chain output
`timescale 1ns/100ps
// Notes on behaviour
// - Shift din MSB first while select low
// - Select rise copies shift into latch
// - No shifting while select is high
// - Host moves select only with clock low
// - Host parks clock low while deselected
// - Power-up clears converter latch
// - Short frame: ten code, two zeros
// - Long frame: four dummies first
// - Latch holds code plus two sub bits
// - Host always sends the two sub bits
// - Chain output changes on falling edges
// - Chain output holds value, never floats
// - Chain delay sixteen cycles plus half (here a bit taken on a rise reaches dout fifteen and a half cycles later)
// - Chained hosts use sixteen bit frames
// - Chain dout to next din, shared lines
// - Byte hosts need two writes
// - Update period sixteen clocks plus gap
// - Zero code saves power
module sdl_dev (
    sdl_link_if.dev link,
    input wire logic reset_n,
    output logic [sdl_pkg::CODE_W-1:0] code,
    output logic [sdl_pkg::SUB_W-1:0] sub_bits,
    output logic dout_oe
);
    typedef struct packed {
        logic [sdl_pkg::SHIFT_W-1:0] shift;
    } sdl_rise_t;
    typedef struct packed {
        logic dout;
    } sdl_fall_t;
    typedef struct packed {
        logic [sdl_pkg::LATCH_W-1:0] latch;
    } sdl_cs_t;
    sdl_rise_t rise_ff;
    sdl_rise_t nxt_rise;
    sdl_fall_t fall_ff;
    sdl_fall_t nxt_fall;
    sdl_cs_t cs_ff;
    sdl_cs_t nxt_cs;
    wire logic [sdl_pkg::SHIFT_W-1:0] shift_in;

    // Each stage takes its lower neighbour; stage zero takes the serial input
    for (genvar b = 0; b < sdl_pkg::SHIFT_W; b++)
    begin : g_shift
        if (b == 0)
        begin : g_head
            assign shift_in[b] = link.din;
        end
        else
        begin : g_body
            assign shift_in[b] = rise_ff.shift[b - 1];
        end
    end

    // Clock edges while deselected leave the register untouched
    always_comb
    begin
        nxt_rise = rise_ff;
        if (!link.cs_n)
        begin
            nxt_rise.shift = shift_in;
        end
    end

    always_ff @(posedge link.sclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rise_ff <= '{shift: sdl_pkg::SHIFT_RST};
        end
        else
        begin
            rise_ff <= nxt_rise;
        end
    end

    // Chain bit moves half a clock after the shift, only while selected
    always_comb
    begin
        nxt_fall = fall_ff;
        if (!link.cs_n)
        begin
            nxt_fall.dout = rise_ff.shift[sdl_pkg::SHIFT_W-1];
        end
    end

    always_ff @(negedge link.sclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fall_ff <= '{dout: sdl_pkg::SHIFT_RST[sdl_pkg::SHIFT_W-1]};
        end
        else
        begin
            fall_ff <= nxt_fall;
        end
    end

    always_comb
    begin
        nxt_cs.latch = rise_ff.shift[sdl_pkg::LATCH_W-1:0];
    end

    // Latch is clocked by the select rising edge
    always_ff @(posedge link.cs_n or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cs_ff <= '{latch: sdl_pkg::LATCH_RST};
        end
        else
        begin
            cs_ff <= nxt_cs;
        end
    end

    assign link.dout = fall_ff.dout;
    assign dout_oe = 1'b1;
    assign code = cs_ff.latch[sdl_pkg::LATCH_W-1:sdl_pkg::SUB_W];
    assign sub_bits = cs_ff.latch[sdl_pkg::SUB_W-1:0];
endmodule

// ===== bench/sdl_link_chk.sv
// Checker on the link wires between host and converter
`timescale 1ns/100ps
module sdl_link_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout
);
    logic [4:0] rises_ff;
    logic cs_q_ff;
    logic sclk_q_ff;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Clock rises seen in the current frame
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rises_ff <= 5'h00;
            cs_q_ff <= 1'b1;
            sclk_q_ff <= 1'b0;
        end
        else
        begin
            cs_q_ff <= cs_n;
            sclk_q_ff <= sclk;
            if (!cs_n && cs_q_ff)
                rises_ff <= 5'h00;
            else if (sclk && !sclk_q_ff)
                rises_ff <= rises_ff + 5'h01;
        end
    end
    sel_clk_low_a: assert property ($changed(cs_n) |-> !sclk && !$past(sclk)) else $error("select moved, clock high");
    idle_clk_low_a: assert property (cs_n |-> !sclk) else $error("clock runs while idle");
    dout_idle_a: assert property (cs_n && $past(cs_n) |-> $stable(dout)) else $error("dout moved while idle");
    dout_edge_a: assert property ($changed(dout) |-> $fell(sclk) && !$past(cs_n)) else $error("dout off fall");
    frame_len_a: assert property ($rose(cs_n) |-> rises_ff == 5'h10) else $error("frame not 16 clocks");
    sclk_half_a: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("clock half period");
    din_change_a: assert property ($changed(din) && !cs_n |-> !sclk) else $error("din moved, clock high");
    cs_gap_a: assert property ($rose(cs_n) |-> cs_n[*3]) else $error("select gap short");
endmodule

// ===== bench/tb_serial_dac_loader.sv
// Bench joining host and converter over the link
`timescale 1ns/100ps
module tb_serial_dac_loader;
    logic mclk = 1'b0;
    logic reset_n = 1'b1;
    logic wr_valid = 1'b0;
    logic [15:0] wr_word = 16'h0000;
    logic wr_ready, rd_valid, dout_oe;
    logic [15:0] rd_word;
    logic [9:0] code;
    logic [1:0] sub_bits;
    logic [15:0] words [4] = '{16'h0804, 16'hf004, 16'h2aa8, 16'h0000};
    int errors = 0;
    int samples_checked = 0;
    int n;
    always #5 mclk = ~mclk;
    sdl_link_if sdl_link_if_i ();
    sdl_host sdl_host_i (.link(sdl_link_if_i), .mclk(mclk), .reset_n(reset_n), .wr_valid(wr_valid),
        .wr_word(wr_word), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_word(rd_word));
    sdl_dev sdl_dev_i (.link(sdl_link_if_i), .reset_n(reset_n), .code(code), .sub_bits(sub_bits),
        .dout_oe(dout_oe));
    sdl_link_chk sdl_link_chk_i (.mclk(mclk), .reset_n(reset_n), .sclk(sdl_link_if_i.sclk),
        .cs_n(sdl_link_if_i.cs_n), .din(sdl_link_if_i.din), .dout(sdl_link_if_i.dout));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One frame through the host, then wait for its read back
    task automatic send(input logic [15:0] w);
        n = 0;
        @(negedge mclk);
        while (wr_ready !== 1'b1 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        wr_valid = 1'b1;
        wr_word = w;
        @(negedge mclk);
        wr_valid = 1'b0;
        while (rd_valid !== 1'b1 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 400)
        begin
            errors++;
            stop_test();
        end
    endtask
    initial
    begin
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (20) @(negedge mclk);
        check({4'h0, code, sub_bits}, 16'h0000);
        reset_n = 1'b1;
        check({15'h0000, dout_oe}, 16'h0001);
        for (int i = 0; i < 4; i++)
        begin
            send(words[i]);
            check({4'h0, code, sub_bits}, {4'h0, words[i][11:0]});
            check(rd_word, i == 0 ? 16'h0000 : words[i - 1]);
        end
        send(words[0]);
        check({4'h0, code, sub_bits}, {4'h0, words[0][11:0]});
        check(rd_word, words[3]);
        // Clear again in mid-run, then one frame from the cleared state
        @(negedge mclk);
        reset_n = 1'b0;
        repeat (2) @(negedge mclk);
        check({4'h0, code, sub_bits}, 16'h0000);
        reset_n = 1'b1;
        send(words[2]);
        check({4'h0, code, sub_bits}, {4'h0, words[2][11:0]});
        check(rd_word, 16'h0000);
        stop_test();
    end
endmodule
